// ### src/dtr_pkg.sv
// Package of shared constants and types for the die temperature readout.
`default_nettype none
package dtr_pkg;
  // ----------------------------------------------------------------------
  // Conversion figures
  // ----------------------------------------------------------------------
  localparam int unsigned CODE_W          = 10;
  localparam int unsigned CONV_CYCLES     = 1024;
  localparam int unsigned CNT_W           = 10;
  localparam logic [CNT_W-1:0] CNT_LAST   = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_RST    = 10'h000;
  localparam logic [CODE_W-1:0] CODE_RST  = 10'h000;
  localparam int unsigned SAMPLE_RATE_SPS = 1000;
  localparam int unsigned CLK_HZ          = 100000000;
  // Sensor clock rate that yields about one conversion per millisecond.
  localparam int unsigned SENSOR_CLK_HZ   = SAMPLE_RATE_SPS * CONV_CYCLES;
  // ----------------------------------------------------------------------
  // Degrees conversion
  // ----------------------------------------------------------------------
  localparam int unsigned GAIN_MUL   = 693;
  localparam int unsigned GAIN_SHIFT = 10;
  localparam int unsigned OFFSET_C   = 265;
  localparam int unsigned DEG_W      = 11;
  localparam logic signed [DEG_W-1:0] DEG_RST = 11'sh000;

  typedef enum logic [1:0] {
    DTR_IDLE  = 2'b00,
    DTR_CONV  = 2'b01,
    DTR_DONE  = 2'b10
  } dtr_state_t;

  // Code to degrees Celsius: code * 693 / 1024 - 265.
  function automatic logic signed [DEG_W-1:0] dtr_to_celsius(input logic [CODE_W-1:0] code);
    logic [19:0] prod;
    prod = 20'(code) * 20'(GAIN_MUL);
    return DEG_W'(signed'({1'b0, prod[19:GAIN_SHIFT]})) - DEG_W'(OFFSET_C);
  endfunction
endpackage
`default_nettype wire

// ### src/dtr_link_if.sv
// Interface joining the sensor end and the core logic end.
`default_nettype none
interface dtr_link_if;
  import dtr_pkg::*;
  logic              sensorCoreEnable;
  logic              sensorReset;
  logic              conversionDonePulse;
  logic [CODE_W-1:0] temperatureCode;

  modport sensor (
    input  sensorCoreEnable,
    input  sensorReset,
    output conversionDonePulse,
    output temperatureCode
  );
  modport core (
    output sensorCoreEnable,
    output sensorReset,
    input  conversionDonePulse,
    input  temperatureCode
  );
endinterface
`default_nettype wire

// ### src/dtr_sensor.sv
// Sensor end: converter sequencer producing 10-bit codes.
`default_nettype none
module dtr_sensor
  import dtr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              userMode,
  input  wire logic [CODE_W-1:0] analogSample,
  dtr_link_if.sensor             link
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // User mode and the analog level come from outside and are synchronised.
  logic              userModeMeta_r;
  logic              userModeSync_r;
  logic [CODE_W-1:0] sampleMeta_r;
  logic [CODE_W-1:0] sampleSync_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      userModeMeta_r <= 1'b0;
      userModeSync_r <= 1'b0;
      sampleMeta_r   <= CODE_RST;
      sampleSync_r   <= CODE_RST;
    end else begin
      userModeMeta_r <= userMode;
      userModeSync_r <= userModeMeta_r;
      sampleMeta_r   <= analogSample;
      sampleSync_r   <= sampleMeta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  dtr_state_t        state_r;
  dtr_state_t        state_nxt;
  logic [CNT_W-1:0]  count_r;
  logic              donePulse_r;
  logic [CODE_W-1:0] code_r;
  logic              active;

  // Outside user mode the converter never runs, so no code is offered.
  assign active = link.sensorCoreEnable & userModeSync_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DTR_IDLE: if (active) state_nxt = DTR_CONV;
      DTR_CONV: begin
        if (!active) state_nxt = DTR_IDLE;
        else if (count_r == CNT_LAST) state_nxt = DTR_DONE;
      end
      // Restart straight away while still enabled.
      DTR_DONE: state_nxt = active ? DTR_CONV : DTR_IDLE;
      default:  state_nxt = DTR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= DTR_IDLE;
    end else if (link.sensorReset) begin
      state_r <= DTR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counter covers 1,025 cycles: 1,024 in counting plus the done cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= CNT_RST;
    end else if (link.sensorReset || state_r != DTR_CONV) begin
      count_r <= CNT_RST;
    end else begin
      count_r <= count_r + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      donePulse_r <= 1'b0;
      code_r      <= CODE_RST;
    end else if (link.sensorReset) begin
      donePulse_r <= 1'b0;
      code_r      <= CODE_RST;
    end else begin
      donePulse_r <= (state_nxt == DTR_DONE) && (state_r == DTR_CONV);
      if ((state_nxt == DTR_DONE) && (state_r == DTR_CONV)) begin
        code_r <= sampleSync_r;
      end
    end
  end

  assign link.conversionDonePulse = donePulse_r;
  assign link.temperatureCode     = code_r;
endmodule // dtr_sensor
`default_nettype wire

// ### src/dtr_core.sv
// Core end: drives enable and reset, captures codes, converts to degrees.
`default_nettype none
module dtr_core
  import dtr_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     measureReq,
  input  wire logic                     sensorClear,
  output logic                          sampleValid,
  output logic        [CODE_W-1:0]      sampleCode,
  output logic signed [DEG_W-1:0]       sampleDegrees,
  dtr_link_if.core                      link
);
  // ----------------------------------------------------------------------
  // Sensor control
  // ----------------------------------------------------------------------
  logic enable_r;
  logic reset_r;
  logic donePrev_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_r <= 1'b0;
      reset_r  <= 1'b1;
    end else begin
      enable_r <= measureReq;
      reset_r  <= sensorClear;
    end
  end

  assign link.sensorCoreEnable = enable_r;
  assign link.sensorReset      = reset_r;

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      donePrev_r    <= 1'b0;
      sampleValid   <= 1'b0;
      sampleCode    <= CODE_RST;
      sampleDegrees <= DEG_RST;
    end else begin
      donePrev_r  <= link.conversionDonePulse;
      sampleValid <= 1'b0;
      // Code is still held by the sensor on the cycle after the pulse.
      if (donePrev_r && !link.conversionDonePulse) begin
        sampleValid   <= 1'b1;
        sampleCode    <= link.temperatureCode;
        sampleDegrees <= dtr_to_celsius(link.temperatureCode);
      end
    end
  end
endmodule // dtr_core
`default_nettype wire

// ### bench/dtr_link_sva.sv
// Checker on the link between the sensor end and the core end.
`default_nettype none
module dtr_link_sva
  import dtr_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              sensorCoreEnable,
  input wire logic              sensorReset,
  input wire logic              conversionDonePulse,
  input wire logic [CODE_W-1:0] temperatureCode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Helper logic
  // ----
  wire logic   pls = conversionDonePulse;
  wire logic   go  = sensorCoreEnable && !sensorReset;
  logic [10:0] gap_r;
  logic        run_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Gap starts saturated so a first pulse never looks too early.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) gap_r <= 11'h7ff;
    else if (pls) gap_r <= 11'h001;
    else if (gap_r != 11'h7ff) gap_r <= gap_r + 11'h001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) run_r <= 1'h0;
    else if (pls) run_r <= go;
    else if (!go) run_r <= 1'h0;
  end
  // ----
  // Assertions
  // ----
  pulse_one_a: assert property (pls |=> !pls) else $error("done pulse too long");
  reset_clear_a: assert property (sensorReset |=> !pls && temperatureCode == 10'h000)
    else $error("reset did not clear");
  code_hold_a: assert property (!pls && !$past(sensorReset) |-> $stable(temperatureCode))
    else $error("code moved without pulse");
  enable_gate_a: assert property (!sensorCoreEnable |=> !pls) else $error("pulse while off");
  conv_len_a: assert property (pls && run_r |-> gap_r == 11'd1025)
    else $error("conversion length wrong");
  stream_run_a: assert property (run_r |-> gap_r <= 11'd1025) else $error("stream stalled");
  rate_limit_a: assert property (pls |-> gap_r >= 11'd1025) else $error("pulses too close");
  cover property (pls && run_r);
  cover property ($rose(sensorReset));
  cover property ($fell(sensorCoreEnable));
  cover property (pls && temperatureCode == 10'h3ff);
endmodule // dtr_link_sva
`default_nettype wire

// ### bench/die_temperature_readout_tb_top.sv
// Testbench joining both ends of the die temperature readout.
`default_nettype none
module die_temperature_readout_tb_top
  import dtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, userMode = 0, measureReq = 0, sensorClear = 0, chkGap = 0;
  logic timedOut = 0;
  logic [CODE_W-1:0] analogSample = 10'h000, sampleCode, c, e;
  logic signed [DEG_W-1:0] sampleDegrees;
  logic sampleValid;
  logic [31:0] seed = 32'h9a6be698;
  int err_count = 0, tests_run = 0, cyc = 0, last = 0, nValid = 0, n0;
  logic [CODE_W-1:0] expQ[$];
  dtr_link_if link ();
  dtr_sensor u_dtr_sensor (.clk(clk), .rst_b(rst_b), .userMode(userMode),
    .analogSample(analogSample), .link(link));
  dtr_core u_dtr_core (.clk(clk), .rst_b(rst_b), .measureReq(measureReq),
    .sensorClear(sensorClear), .sampleValid(sampleValid), .sampleCode(sampleCode),
    .sampleDegrees(sampleDegrees), .link(link));
  dtr_link_sva u_dtr_link_sva (.clk(clk), .rst_b(rst_b),
    .sensorCoreEnable(link.sensorCoreEnable), .sensorReset(link.sensorReset),
    .conversionDonePulse(link.conversionDonePulse), .temperatureCode(link.temperatureCode));
  initial forever #5 clk = ~clk;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic signed [DEG_W-1:0] deg(input logic [CODE_W-1:0] v);
    return DEG_W'((int'(v) * 693) / 1024 - 265);
  endfunction
  task automatic cmpVal(input string n, input logic [10:0] x, input logic [10:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cmpInt(input string n, input int x, input int g);
    tests_run++;
    if (g != x) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", n, x, g);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic waitValid(input int lim);
    int k;
    k = 0;
    while (sampleValid !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    // A timeout stops the remaining scenarios and goes to the verdict.
    if (k >= lim) begin
      err_count++;
      timedOut = 1'b1;
      $display("Error waitValid expected valid within %0d seen none", lim);
    end
    @(posedge clk);
  endtask
  // ----
  // Monitor
  // ----
  always @(posedge clk) begin
    cyc++;
    if (link.conversionDonePulse === 1'b1) begin
      if (chkGap) cmpInt("pulseGap", 1025, cyc - last);
      last = cyc;
    end
    if (sampleValid === 1'b1) begin
      nValid++;
      e = expQ.size() > 0 ? expQ.pop_front() : 'x;
      cmpVal("sampleCode", 11'(e), 11'(sampleCode));
      cmpVal("sampleDegrees", deg(e), sampleDegrees);
    end
  end
  // ----
  // Stimulus
  // ----
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    userMode <= 1;
    measureReq <= 1;
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      c = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : seed[9:0];
      analogSample <= c;
      expQ.push_back(c);
      if (i == 4) begin
        chkGap = 0;
        repeat (500) @(posedge clk);
        sensorClear <= 1;
        n0 = nValid;
        repeat (1100) @(posedge clk);
        cmpInt("validsInClear", n0, nValid);
        sensorClear <= 0;
      end
      waitValid(1200);
      if (timedOut) break;
      if (i == 0) chkGap = 1;
    end
    if (!timedOut) begin
      $display("stream and clear tests done");
      // Dropping enable mid-conversion must abort it without a code.
      measureReq <= 0;
      n0 = nValid;
      repeat (1100) @(posedge clk);
      cmpInt("validsNoEnable", n0, nValid);
      $display("enable test done");
      measureReq <= 1;
      sensorClear <= 1;
      userMode <= 0;
      repeat (3) @(posedge clk);
      sensorClear <= 0;
      n0 = nValid;
      repeat (2200) @(posedge clk);
      cmpInt("validsNoUserMode", n0, nValid);
      $display("user mode test done");
    end
    print_verdict();
  end
endmodule // die_temperature_readout_tb_top
`default_nettype wire
